//--- logic/switch_detect_status_regs.v
// Status register bank with serial frame port and settings check value
`include "status_bank_defines.vh"
module switch_detect_status_regs #(
    parameter INPUTS  = 24,
    parameter CFG_AW  = 3
) (
    input  wire              clk_in,
    input  wire              reset_in,
    input  wire              cs_n_in,
    input  wire              sclk_in,
    input  wire              mosi_in,
    output reg               miso_out,
    output reg               miso_oe_out,
    output reg               spi_error_out,
    output reg               frame_parity_error_out,
    output reg  [15:0]       check_value_out,
    input  wire              adc_fault_in,
    input  wire              sink3_fault_in,
    input  wire              sink2_fault_in,
    input  wire              source1_fault_in,
    input  wire              source0_fault_in,
    input  wire              supply_window_a_low_in,
    input  wire              supply_window_a_high_in,
    input  wire              supply_window_b_low_in,
    input  wire              supply_window_b_high_in,
    input  wire              supply_low_flag_in,
    input  wire              supply_high_flag_in,
    input  wire              thermal_warning_flag_in,
    input  wire              thermal_shutdown_flag_in,
    input  wire [INPUTS-1:0] comp_level_in
);
    localparam CHK_IDLE  = 2'd0;
    localparam CHK_FETCH = 2'd1;
    localparam CHK_LOAD  = 2'd2;
    localparam CHK_SHIFT = 2'd3;

    // Encodes one supply window from its two threshold comparisons
    function [1:0] window_code;
        input at_low;
        input at_high;
        begin
            if (at_high) begin
                window_code = `WIN_ABOVE;
            end else if (at_low) begin
                window_code = `WIN_BETWEEN;
            end else begin
                window_code = `WIN_BELOW;
            end
        end
    endfunction

    function in_cfg;
        input [`ADDR_W-1:0] a;
        begin
            in_cfg = (a >= `ADDR_CFG_BASE) && (a < `ADDR_CFG_BASE + `CFG_WORDS);
        end
    endfunction

    function [CFG_AW-1:0] cfg_index;
        input [`ADDR_W-1:0] a;
        reg   [`ADDR_W-1:0] d;
        begin
            d = a - `ADDR_CFG_BASE;
            cfg_index = d[CFG_AW-1:0];
        end
    endfunction

    // One message bit into CRC-CCITT, message MSB first
    function [15:0] check_step;
        input [15:0] acc;
        input        bit_in;
        begin
            if (acc[15] ^ bit_in) begin
                check_step = {acc[14:0], 1'b0} ^ `CHECK_POLY;
            end else begin
                check_step = {acc[14:0], 1'b0};
            end
        end
    endfunction

    // Synchronisers for pins and status levels
    reg [2:0]        pin_meta;
    reg [2:0]        pin_sync;
    reg [12:0]       stat_meta;
    reg [12:0]       stat_sync;
    reg [INPUTS-1:0] comp_meta;
    reg [INPUTS-1:0] comp_sync;
    reg              sclk_prev;
    reg              cs_n_prev;

    reg              soft_reset;
    wire             rst = reset_in | soft_reset;

    reg [23:0]       misc_status;
    reg [23:0]       comp_levels;

    reg [31:0]       rx_shift;
    reg [6:0]        bit_count;
    reg [31:0]       tx_word;
    reg              rd_stage1;
    reg              rd_stage2;
    reg              cfg_write;
    reg [CFG_AW-1:0] cfg_waddr;
    reg [23:0]       cfg_wdata;

    reg [1:0]        chk_state;
    reg [15:0]       chk_acc;
    reg [CFG_AW-1:0] chk_idx;
    reg [4:0]        chk_bit;
    reg [23:0]       chk_word;

    wire [23:0]      mem_a_data;
    wire [23:0]      mem_b_data;
    wire [`ADDR_W-1:0] rx_addr = rx_shift[`ADDR_W-1:0];

    wire cs_n_s  = pin_sync[2];
    wire sclk_s  = pin_sync[1];
    wire mosi_s  = pin_sync[0];
    wire sclk_rise = sclk_s & ~sclk_prev & ~cs_n_s;
    wire sclk_fall = ~sclk_s & sclk_prev & ~cs_n_s;
    wire frame_start = cs_n_prev & ~cs_n_s;
    wire frame_end   = ~cs_n_prev & cs_n_s;
    wire chk_busy    = (chk_state != CHK_IDLE);

    wire frame_ok    = (bit_count == `FRAME_BITS) && (^rx_shift);
    wire [`ADDR_W-1:0] f_addr = rx_shift[`FRAME_ADDR_HI:`FRAME_ADDR_LO];

    settings_memory #(
        .WIDTH (`DATA_W),
        .DEPTH (`CFG_WORDS),
        .AW    (CFG_AW)
    ) u_settings (
        .clk_in          (clk_in),
        .clear_in        (rst),
        .write_en_in     (cfg_write),
        .write_addr_in   (cfg_waddr),
        .write_data_in   (cfg_wdata),
        .read_addr_a_in  (chk_idx),
        .read_data_a_out (mem_a_data),
        .read_addr_b_in  (cfg_index(rx_addr)),
        .read_data_b_out (mem_b_data)
    );

    // Read value of one address, no side effects
    function [23:0] read_value;
        input [`ADDR_W-1:0] a;
        begin
            if (a == `ADDR_CHECK_VALUE) begin
                read_value = {8'h00, check_value_out}; // RULE1 RULE2
            end else if (a == `ADDR_MISC_STATUS) begin
                read_value = misc_status;                // RULE18
            end else if (a == `ADDR_COMP_LEVELS) begin
                read_value = comp_levels;
            end else if (in_cfg(a)) begin
                read_value = mem_b_data;
            end else begin
                read_value = 24'h000000;
            end
        end
    endfunction

    always @(posedge clk_in) begin
        if (reset_in) begin
            // Idle pin levels, so no false sclk edge follows reset
            pin_meta  <= 3'h4;
            pin_sync  <= 3'h4;
            stat_meta <= 13'h0000;
            stat_sync <= 13'h0000;
            comp_meta <= {INPUTS{1'b0}};
            comp_sync <= {INPUTS{1'b0}};
            sclk_prev <= 1'b0;
            cs_n_prev <= 1'b1;
        end else begin
            pin_meta  <= {cs_n_in, sclk_in, mosi_in};
            pin_sync  <= pin_meta;
            stat_meta <= {adc_fault_in, sink3_fault_in, sink2_fault_in,
                          source1_fault_in, source0_fault_in,
                          supply_window_b_high_in, supply_window_b_low_in,
                          supply_window_a_high_in, supply_window_a_low_in,
                          supply_low_flag_in, supply_high_flag_in,
                          thermal_warning_flag_in, thermal_shutdown_flag_in};
            stat_sync <= stat_meta;
            comp_meta <= comp_level_in;
            comp_sync <= comp_meta;
            sclk_prev <= sclk_s;
            cs_n_prev <= cs_n_s;
        end
    end

    // Status words follow live conditions every cycle
    always @(posedge clk_in) begin
        if (rst) begin // RULE17
            misc_status <= `MISC_RESET;
            comp_levels <= `COMP_RESET;
        end else begin
            misc_status <= 24'h000000; // RULE12
            misc_status[`MISC_ADC_FAULT] <= stat_sync[12]; // RULE4
            misc_status[`MISC_SINK3]     <= stat_sync[11]; // RULE5
            misc_status[`MISC_SINK2]     <= stat_sync[10]; // RULE5
            misc_status[`MISC_SOURCE1]   <= stat_sync[9];  // RULE6
            misc_status[`MISC_SOURCE0]   <= stat_sync[8];  // RULE6
            misc_status[`MISC_WIN_B_HI:`MISC_WIN_B_LO] <=
                window_code(stat_sync[6], stat_sync[7]);    // RULE7
            misc_status[`MISC_WIN_A_HI:`MISC_WIN_A_LO] <=
                window_code(stat_sync[4], stat_sync[5]);    // RULE7
            misc_status[`MISC_SUPPLY_LOW]  <= stat_sync[3]; // RULE8
            misc_status[`MISC_SUPPLY_HIGH] <= stat_sync[2]; // RULE9
            misc_status[`MISC_THERM_WARN]  <= stat_sync[1]; // RULE10
            misc_status[`MISC_THERM_SHUT]  <= stat_sync[0]; // RULE11
            comp_levels <= comp_sync;                       // RULE13
        end
    end

    // Serial frame engine
    always @(posedge clk_in) begin
        if (rst) begin
            rx_shift               <= 32'h00000000;
            bit_count              <= 7'h00;
            tx_word                <= 32'h00000000;
            rd_stage1              <= 1'b0;
            rd_stage2              <= 1'b0;
            cfg_write              <= 1'b0;
            cfg_waddr              <= {CFG_AW{1'b0}};
            cfg_wdata              <= 24'h000000;
            miso_out               <= 1'b0;
            miso_oe_out            <= 1'b0;
            spi_error_out          <= 1'b0;
            frame_parity_error_out <= 1'b0;
            soft_reset             <= 1'b0;
        end else begin
            cfg_write   <= 1'b0;
            soft_reset  <= 1'b0;
            rd_stage1   <= sclk_rise && (bit_count == `FRAME_ADDR_DONE);
            rd_stage2   <= rd_stage1;
            miso_oe_out <= ~cs_n_s;
            // Data line returns low together with its enable
            if (cs_n_s) begin
                miso_out <= 1'b0;
            end
            if (frame_start) begin
                rx_shift  <= 32'h00000000;
                bit_count <= 7'h00;
                tx_word   <= {spi_error_out, frame_parity_error_out, chk_busy, 29'h0};
                miso_out  <= spi_error_out;
                // Flags are cleared once reported; a new error below still wins
                spi_error_out          <= 1'b0;
                frame_parity_error_out <= 1'b0;
            end
            if (sclk_rise) begin
                rx_shift <= {rx_shift[30:0], mosi_s};
                if (bit_count != 7'h7F) begin
                    bit_count <= bit_count + 7'h01;
                end
            end
            if (rd_stage2) begin
                tx_word[`FRAME_DATA_HI:`FRAME_DATA_LO] <= read_value(rx_addr);
                tx_word[0] <= ~(^{tx_word[31:25], read_value(rx_addr)});
            end
            if (sclk_fall && (bit_count < `FRAME_BITS)) begin
                miso_out <= tx_word[5'd31 - bit_count[4:0]];
            end
            if (frame_end) begin
                if (bit_count != 7'h00 && bit_count != `FRAME_BITS) begin
                    spi_error_out <= 1'b1; // RULE15
                end else if (bit_count == `FRAME_BITS && !(^rx_shift)) begin
                    frame_parity_error_out <= 1'b1; // RULE16
                end else if (frame_ok && rx_shift[`FRAME_RW_BIT]) begin
                    // Status addresses are not writable and fall through here
                    if (in_cfg(f_addr)) begin // RULE14
                        cfg_write <= 1'b1;
                        cfg_waddr <= cfg_index(f_addr);
                        cfg_wdata <= rx_shift[`FRAME_DATA_HI:`FRAME_DATA_LO];
                    end else if (f_addr == `ADDR_SOFT_RESET) begin
                        soft_reset <= 1'b1; // RULE17
                    end
                end
            end
        end
    end

    // Check value walk over all settings words
    always @(posedge clk_in) begin
        if (rst) begin
            chk_state       <= CHK_IDLE;
            chk_acc         <= `CHECK_RESET;
            chk_idx         <= {CFG_AW{1'b0}};
            chk_bit         <= 5'd0;
            chk_word        <= 24'h000000;
            check_value_out <= `CHECK_RESET; // RULE1
        end else if (cfg_write) begin
            chk_state <= CHK_FETCH; // RULE19
            chk_acc   <= `CHECK_RESET;
            chk_idx   <= {CFG_AW{1'b0}};
        end else begin
            case (chk_state)
                CHK_FETCH: begin
                    chk_state <= CHK_LOAD;
                end
                CHK_LOAD: begin
                    chk_word  <= mem_a_data;
                    chk_bit   <= 5'd23;
                    chk_state <= CHK_SHIFT;
                end
                CHK_SHIFT: begin
                    chk_acc  <= check_step(chk_acc, chk_word[23]);
                    chk_word <= {chk_word[22:0], 1'b0};
                    if (chk_bit != 5'd0) begin
                        chk_bit <= chk_bit - 5'd1;
                    end else if (chk_idx == `CFG_WORDS - 1) begin
                        check_value_out <= check_step(chk_acc, chk_word[23]); // RULE2
                        chk_state       <= CHK_IDLE;
                    end else begin
                        chk_idx   <= chk_idx + {{(CFG_AW-1){1'b0}}, 1'b1};
                        chk_state <= CHK_FETCH;
                    end
                end
                default: begin
                    chk_state <= CHK_IDLE;
                end
            endcase
        end
    end
endmodule // switch_detect_status_regs

//--- logic/status_bank_defines.vh
// Constants for the switch-detect status register bank and its serial frame
// Functional notes
// RULE1: Register 0x3 bits 15-0 hold CRC-CCITT over settings, FFFF after reset.
// RULE2: CRC least significant bit sits at bit 0, most significant at bit 15.
// RULE3: Host should compute its own CRC and compare with the check value.
// RULE4: Register 0x4 bit 12 reads 1 when converter self-test found an error.
// RULE5: Bits 11 and 10 flag abnormal current sinks on inputs 3 and 2.
// RULE6: Bits 9 and 8 flag abnormal current sources on inputs 1 and 0.
// RULE7: Supply window fields 7-6 and 5-4 encode below, between, above; 3 unused.
// RULE8: Bit 3 reads 1 while supply is under the under-voltage threshold.
// RULE9: Bit 2 reads 1 while supply is over the over-voltage threshold.
// RULE10: Bit 1 reads 1 while junction temperature exceeds the warning threshold.
// RULE11: Bit 0 reads 1 while junction temperature exceeds the shutdown threshold.
// RULE12: Misc register holds only device conditions; bits 23-13 read zero.
// RULE13: Register 0x5 bit n shows comparator level of input n, 24 inputs.
// RULE14: Status fields are read-only; host writes leave them unchanged.
// RULE15: Frames with other than exactly 32 clocks are dropped, error flag set; a frame with no clocks sets no flag.
// RULE16: Frames use odd parity; frames with even count of ones are dropped.
// RULE17: Any reset returns all registers to defaults and restarts the machines.
// RULE18: Reads have no side effect; status fields track live conditions.
// RULE19: Check value is recomputed after every configuration write.
`ifndef STATUS_BANK_DEFINES_VH
`define STATUS_BANK_DEFINES_VH

`define ADDR_W             6
`define DATA_W             24
`define ADDR_CHECK_VALUE   6'h03
`define ADDR_MISC_STATUS   6'h04
`define ADDR_COMP_LEVELS   6'h05
`define ADDR_CFG_BASE      6'h1A
`define CFG_WORDS          8
`define ADDR_SOFT_RESET    6'h3E

`define CHECK_RESET        16'hFFFF
`define CHECK_POLY         16'h1021
`define MISC_RESET         24'h000000
`define COMP_RESET         24'h000000

`define MISC_ADC_FAULT     12
`define MISC_SINK3         11
`define MISC_SINK2         10
`define MISC_SOURCE1       9
`define MISC_SOURCE0       8
`define MISC_WIN_B_HI      7
`define MISC_WIN_B_LO      6
`define MISC_WIN_A_HI      5
`define MISC_WIN_A_LO      4
`define MISC_SUPPLY_LOW    3
`define MISC_SUPPLY_HIGH   2
`define MISC_THERM_WARN    1
`define MISC_THERM_SHUT    0

`define WIN_BELOW          2'h0
`define WIN_BETWEEN        2'h1
`define WIN_ABOVE          2'h2

`define FRAME_BITS         7'h20
`define FRAME_RW_BIT       31
`define FRAME_ADDR_HI      30
`define FRAME_ADDR_LO      25
`define FRAME_DATA_HI      24
`define FRAME_DATA_LO      1
`define FRAME_ADDR_DONE    7'h06
`define ST_SPI_ERR         31
`define ST_PARITY_ERR      30
`define ST_CHECK_BUSY      29

`endif

//--- logic/settings_memory.v
// Configuration word store with two registered read ports
module settings_memory #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_in,
    input  wire             clear_in,
    input  wire             write_en_in,
    input  wire [AW-1:0]    write_addr_in,
    input  wire [WIDTH-1:0] write_data_in,
    input  wire [AW-1:0]    read_addr_a_in,
    output reg  [WIDTH-1:0] read_data_a_out,
    input  wire [AW-1:0]    read_addr_b_in,
    output reg  [WIDTH-1:0] read_data_b_out
);
    reg [WIDTH-1:0] words [0:DEPTH-1];
    integer i;

    always @(posedge clk_in) begin
        if (clear_in) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                words[i] <= {WIDTH{1'b0}};
            end
            read_data_a_out <= {WIDTH{1'b0}};
            read_data_b_out <= {WIDTH{1'b0}};
        end else begin
            if (write_en_in) begin
                words[write_addr_in] <= write_data_in;
            end
            read_data_a_out <= words[read_addr_a_in];
            read_data_b_out <= words[read_addr_b_in];
        end
    end
endmodule // settings_memory

//--- verif/status_bank_props.sv
// Concurrent checks on the serial port pins and flags of the status bank
module status_bank_props (
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic        cs_n_in,
    input wire logic        sclk_in,
    input wire logic        miso_out,
    input wire logic        miso_oe_out,
    input wire logic        spi_error_out,
    input wire logic        frame_parity_error_out,
    input wire logic [15:0] check_value_out
);
    timeunit 1ns;
    timeprecision 100ps;
    reset_defaults_a: assert property (@(posedge clk_in) reset_in |=>
        check_value_out == 16'hFFFF && !miso_oe_out && !spi_error_out && !frame_parity_error_out)
        else $error("reset values wrong");
    drive_on_select_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $fell(cs_n_in) |-> ##[1:4] (miso_oe_out || cs_n_in)) else $error("miso not driven");
    drive_off_deselect_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(cs_n_in) |-> ##[1:5] (!miso_oe_out || !cs_n_in)) else $error("miso not released");
    idle_miso_low_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !miso_oe_out |-> !miso_out) else $error("miso active while released");
    miso_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !cs_n_in && sclk_in && $past(sclk_in, 3) && $past(miso_oe_out, 3) |-> $stable(miso_out))
        else $error("miso moved while sclk high");
    spi_flag_sticky_a: assert property (@(posedge clk_in) disable iff (reset_in)
        spi_error_out && cs_n_in |=> spi_error_out) else $error("spi error flag lost");
    parity_flag_sticky_a: assert property (@(posedge clk_in) disable iff (reset_in)
        frame_parity_error_out && cs_n_in |=> frame_parity_error_out)
        else $error("parity flag lost");
    flag_at_frame_end_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(spi_error_out) || $rose(frame_parity_error_out) |-> $past(cs_n_in, 2))
        else $error("error flag raised inside a frame");
endmodule // status_bank_props

bind switch_detect_status_regs status_bank_props props_i (
    .clk_in(clk_in), .reset_in(reset_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
    .miso_out(miso_out), .miso_oe_out(miso_oe_out), .spi_error_out(spi_error_out),
    .frame_parity_error_out(frame_parity_error_out), .check_value_out(check_value_out));

//--- verif/spi_host_model.sv
// Host side of the serial link: mode 0 frames, MSB first, 80 ns sclk
module spi_host_model (
    input  wire logic clk_in,
    input  wire logic miso_in,
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      mosi_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = 32'h0;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        mosi_out <= tx[31];
        repeat (8) @(posedge clk_in);
        for (int i = 0; i < nbits; i++) begin
            @(negedge clk_in);
            rx[31 - i] = miso_in;
            @(posedge clk_in);
            sclk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            sclk_out <= 1'b0;
            if (i < 31) mosi_out <= tx[30 - i];
            repeat (3) @(posedge clk_in);
        end
        @(posedge clk_in);
        cs_n_out <= 1'b1;
        // Released line must not keep showing the last bit
        mosi_out <= ~mosi_out;
        repeat (8) @(posedge clk_in);
    endtask
endmodule // spi_host_model

//--- verif/test_switch_detect_status_regs.sv
// Self-checking bench for the switch-detect status register bank
`include "status_bank_defines.vh"
module test_switch_detect_status_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_in;
    logic        reset_in;
    logic [12:0] st;
    logic [23:0] comp;
    logic        cs_n, sclk, mosi, miso, miso_oe, spi_err, par_err;
    wire         miso_w = miso_oe ? miso : 1'bz;
    logic [15:0] chk;
    logic [31:0] rx;
    logic [23:0] cfg [8];
    logic [23:0] pats [3] = '{24'hA5C3E1, 24'h5A3C1E, 24'h800001};
    int          err_total, checked;
    switch_detect_status_regs dut (
        .clk_in(clk_in), .reset_in(reset_in), .cs_n_in(cs_n), .sclk_in(sclk),
        .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .spi_error_out(spi_err),
        .frame_parity_error_out(par_err), .check_value_out(chk),
        .adc_fault_in(st[12]), .sink3_fault_in(st[11]), .sink2_fault_in(st[10]),
        .source1_fault_in(st[9]), .source0_fault_in(st[8]),
        .supply_window_b_high_in(st[7]), .supply_window_b_low_in(st[6]),
        .supply_window_a_high_in(st[5]), .supply_window_a_low_in(st[4]),
        .supply_low_flag_in(st[3]), .supply_high_flag_in(st[2]),
        .thermal_warning_flag_in(st[1]), .thermal_shutdown_flag_in(st[0]),
        .comp_level_in(comp));
    spi_host_model host (.clk_in(clk_in), .miso_in(miso_w), .cs_n_out(cs_n),
        .sclk_out(sclk), .mosi_out(mosi));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic print_verdict();
        $display("TB: %0d checks, %0d mismatches", checked, err_total);
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic frame(input logic wr, input logic [5:0] a, input logic [23:0] d,
                         input int n, input logic bad);
        logic [31:0] tx;
        tx = {wr, a, d, 1'b0};
        tx[0] = ~^tx[31:1] ^ bad;
        host.xfer(tx, n, rx);
        if (n == 32) check(rx[0], ~^rx[31:1]);
    endtask
    task automatic rd(input logic [5:0] a, input logic [23:0] want);
        frame(1'b0, a, 24'h0, 32, 1'b0);
        check({8'h0, rx[24:1]}, {8'h0, want});
    endtask
    function automatic logic [23:0] misc_of(input logic [12:0] s);
        logic [1:0] wa, wb;
        wb = s[7] ? `WIN_ABOVE : (s[6] ? `WIN_BETWEEN : `WIN_BELOW);
        wa = s[5] ? `WIN_ABOVE : (s[4] ? `WIN_BETWEEN : `WIN_BELOW);
        return {11'h0, s[12:8], wb, wa, s[3:0]};
    endfunction
    // Host-side reference of the settings check value
    function automatic logic [15:0] crc_of();
        logic [15:0] c;
        c = 16'hFFFF;
        for (int w = 0; w < 8; w++)
            for (int b = 23; b >= 0; b--)
                c = {c[14:0], 1'b0} ^ ((c[15] ^ cfg[w][b]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    initial begin
        #400us;
        err_total++;
        print_verdict();
    end
    initial begin
        err_total = 0;
        checked = 0;
        reset_in = 1'b1;
        st = 13'h0;
        comp = 24'h0;
        tick(3);
        reset_in <= 1'b0;
        tick(4);
        check(chk, 16'hFFFF);
        rd(6'h03, 24'h00FFFF);
        rd(6'h04, 24'h0);
        rd(6'h05, 24'h0);
        $display("TB: reset test done");
        for (int k = 0; k < 15; k++) begin
            st <= (k < 13) ? 13'h1 << k : ((k == 13) ? 13'h0F0 : 13'h1FFF);
            tick(5);
            rd(6'h04, misc_of(st));
        end
        rd(6'h04, misc_of(st));
        for (int p = 0; p < 3; p++) begin
            comp <= pats[p];
            tick(5);
            rd(6'h05, pats[p]);
        end
        $display("TB: status test done");
        for (int a = 3; a < 6; a++) frame(1'b1, 6'(a), 24'h123456, 32, 1'b0);
        frame(1'b1, 6'h30, 24'h123456, 32, 1'b0);
        tick(250);
        rd(6'h03, 24'h00FFFF);
        rd(6'h04, misc_of(st));
        rd(6'h05, comp);
        rd(6'h30, 24'h0);
        $display("TB: read-only test done");
        for (int w = 0; w < 8; w++) begin
            cfg[w] = 24'(24'h1000A5 * (w + 1));
            frame(1'b1, `ADDR_CFG_BASE + 6'(w), cfg[w], 32, 1'b0);
            check(rx[31:29], (w > 0) ? 3'b001 : 3'b000);
        end
        tick(250);
        check(chk, crc_of());
        rd(6'h03, {8'h0, crc_of()});
        rd(`ADDR_CFG_BASE + 6'h07, cfg[7]);
        $display("TB: check value test done");
        frame(1'b1, `ADDR_CFG_BASE, 24'hFFFFFF, 31, 1'b0);
        check(spi_err, 1'b1);
        frame(1'b1, `ADDR_CFG_BASE, 24'hFFFFFF, 32, 1'b1);
        check(rx[31], 1'b1);
        check(par_err, 1'b1);
        rd(6'h04, misc_of(st));
        check(rx[31:30], 2'b01);
        check({spi_err, par_err}, 2'b00);
        frame(1'b0, 6'h04, 24'h0, 0, 1'b0);
        check(spi_err, 1'b0);
        tick(250);
        check(chk, crc_of());
        $display("TB: frame error test done");
        frame(1'b1, `ADDR_SOFT_RESET, 24'h0, 32, 1'b0);
        check(chk, 16'hFFFF);
        rd(`ADDR_CFG_BASE, 24'h0);
        for (int w = 0; w < 8; w++) cfg[w] = 24'h000000;
        cfg[0] = 24'h00ABCD;
        frame(1'b1, `ADDR_CFG_BASE, 24'h00ABCD, 32, 1'b0);
        tick(250);
        check(chk, crc_of());
        reset_in <= 1'b1;
        tick(3);
        reset_in <= 1'b0;
        tick(4);
        check(chk, 16'hFFFF);
        $display("TB: reset test done");
        print_verdict();
    end
endmodule // test_switch_detect_status_regs
